// *** src/cra_core_regs.sv ***
`timescale 1ns/1ps
module cra_core_regs
  import cra_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // timing control
  input wire logic osc_rc,
  input wire logic [2:0] cyc_len,
  output logic tick,
  output cra_state_t state,
  output logic [2:0] mcycle,
  output logic instr_start,
  // program counter control
  input wire logic pc_inc,
  input wire logic pc_load,
  input wire logic [11:0] pc_value,
  input wire logic zp_call,
  input wire logic [2:0] zp_index,
  input wire logic intr_take,
  input wire logic [3:0] intr_index,
  output logic [11:0] program_counter,
  output logic fetch_in_test,
  output logic intr_busy,
  // register write and read
  input wire logic reg_wr,
  input wire logic reg_byte,
  input wire cra_reg_t reg_sel,
  input wire logic [7:0] reg_wdata,
  input wire logic rd_en,
  input wire logic rd_byte,
  input wire cra_reg_t rd_sel,
  output logic [7:0] rd_data,
  output logic rd_refused,
  // carry
  input wire logic carry_we,
  input wire logic carry_in,
  output logic carry,
  // stack
  input wire logic sp_push,
  input wire logic sp_pop,
  input wire logic [7:0] push_data,
  output logic [7:0] stack_pointer,
  // data memory request
  input wire logic mem_req,
  input wire cra_mode_t mem_mode,
  input wire logic [7:0] mem_dir,
  input wire logic mem_we,
  input wire logic mem_byte,
  input wire logic [7:0] mem_wdata,
  // data memory port
  output logic [10:0] dmem_addr,
  output logic dmem_en,
  output logic dmem_we,
  output logic dmem_byte,
  output logic [7:0] dmem_wdata,
  output logic dmem_sfr,
  output logic dmem_stack
);
  // working nibbles
  logic [3:0] acc_a, acc_b, idx_h, idx_l, idx_x, idx_y;
  // bank selection state
  logic [2:0] primary_bank_select, secondary_bank_select;
  logic bank_common_flag, bank_enable_flag;
  // interrupt save state
  cra_save_t save_st;
  // arbitration terms
  logic idle, do_intr, do_push, do_pop, do_spwr, mem_go;
  // stack pointer neighbours
  logic [7:0] sp_dn, sp_up;
  // next values
  logic [11:0] next_pc;
  logic [2:0] next_bank;
  logic [7:0] bank_byte;

  // state generator
  // clock source choice
  cra_timing cra_timing_i (
    .clk(clk),
    .rst_n(rst_n),
    .osc_rc(osc_rc),
    .cyc_len(cyc_len),
    .tick(tick),
    .state(state),
    .mcycle(mcycle),
    .instr_start(instr_start)
  );

  // bank number from a select value
  // lsb picks bank
  function automatic logic [2:0] bank_of(input logic [2:0] bsr);
    return bsr[0] ? BANK7 : BANK0;
  endfunction

  // byte pair address of a stack slot
  // bank 7, bit 0 dropped
  function automatic logic [10:0] stack_addr(input logic [7:0] sp);
    return {BANK7, sp[7:1], 1'b0};
  endfunction

  // one request per cycle, interrupt first
  assign idle = (save_st == SV_IDLE);
  assign do_intr = intr_take && idle;
  assign do_push = sp_push && idle && !intr_take;
  assign do_pop = sp_pop && !sp_push && idle && !intr_take;
  assign do_spwr = reg_wr && reg_byte && reg_sel == R_SP && idle
    && !intr_take && !sp_push && !sp_pop;
  assign mem_go = mem_req && idle && !intr_take && !sp_push && !sp_pop;
  assign sp_dn = {1'b1, stack_pointer[6:1] - SP_STEP, 1'b1};
  assign sp_up = {1'b1, stack_pointer[6:1] + SP_STEP, 1'b1};
  assign bank_byte = {bank_common_flag, bank_enable_flag,
    secondary_bank_select, primary_bank_select};

  // next program address
  always_comb
  begin
    next_pc = program_counter;
    if (do_intr)
      next_pc = INT_BASE + {7'h00,
        (intr_index > INT_IDX_MAX ? INT_IDX_MAX : intr_index), 1'b0};
    else if (zp_call)
      next_pc = ZPC_BASE + {8'h00, zp_index, 1'b0};
    else if (pc_load)
      next_pc = pc_value;
    else if (pc_inc)
      next_pc = program_counter + 12'h001;
  end

  // program counter and test area flag
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      program_counter <= PC_RESET;
      fetch_in_test <= 1'b0;
    end
    else
    begin
      program_counter <= next_pc;
      fetch_in_test <= (next_pc >= TEST_BASE);
    end
  end

  // interrupt save sequencer
  // ba then hl
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      save_st <= SV_IDLE;
    else
    begin
      case (save_st)
        SV_IDLE: save_st <= do_intr ? SV_BA : SV_IDLE;
        SV_BA: save_st <= SV_HL;
        SV_HL: save_st <= SV_C;
        default: save_st <= SV_IDLE;
      endcase
    end
  end

  // busy flag while saving
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      intr_busy <= 1'b0;
    else
      intr_busy <= do_intr || (save_st != SV_IDLE && save_st != SV_C);
  end

  // stack pointer
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      stack_pointer <= SP_RESET;
    else if (save_st != SV_IDLE || do_push)
      stack_pointer <= sp_dn;
    else if (do_pop)
      stack_pointer <= sp_up;
    else if (do_spwr)
      stack_pointer <= {1'b1, reg_wdata[6:1], 1'b1};
  end

  // accumulator and index registers
  // pairs as bytes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      acc_a <= 4'h0;
      acc_b <= 4'h0;
      idx_h <= 4'h0;
      idx_l <= 4'h0;
      idx_x <= 4'h0;
      idx_y <= 4'h0;
    end
    else if (reg_wr && reg_byte)
    begin
      case (reg_sel)
        R_A, R_B: {acc_b, acc_a} <= reg_wdata;
        R_H, R_L: {idx_h, idx_l} <= reg_wdata;
        R_X, R_Y: {idx_x, idx_y} <= reg_wdata;
        default: ;
      endcase
    end
    else if (reg_wr)
    begin
      case (reg_sel)
        R_A: acc_a <= reg_wdata[3:0];
        R_B: acc_b <= reg_wdata[3:0];
        R_H: idx_h <= reg_wdata[3:0];
        R_L: idx_l <= reg_wdata[3:0];
        R_X: idx_x <= reg_wdata[3:0];
        R_Y: idx_y <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  // bank selects and flags, byte write only
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      primary_bank_select <= 3'h0;
      secondary_bank_select <= 3'h0;
      bank_enable_flag <= 1'b0;
      bank_common_flag <= 1'b0;
    end
    else if (reg_wr && reg_byte && reg_sel == R_BANK)
    begin
      primary_bank_select <= reg_wdata[BK_PRIMARY_BANK_SELECT_LSB +: 3];
      secondary_bank_select <= reg_wdata[BK_SECONDARY_BANK_SELECT_LSB +: 3];
      bank_enable_flag <= reg_wdata[BK_BEF_BIT];
      bank_common_flag <= reg_wdata[BK_BCF_BIT];
    end
  end

  // carry flag
  // carry or borrow
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      carry <= 1'b0;
    else if (carry_we)
      carry <= carry_in;
  end

  // register read port
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_data <= 8'h00;
      rd_refused <= 1'b0;
    end
    else if (rd_en && rd_byte)
    begin
      rd_refused <= 1'b0;
      case (rd_sel)
        R_A, R_B: rd_data <= {acc_b, acc_a};
        R_H, R_L: rd_data <= {idx_h, idx_l};
        R_X, R_Y: rd_data <= {idx_x, idx_y};
        R_SP: rd_data <= {1'b1, stack_pointer[6:1], 1'b1};
        default: rd_data <= bank_byte;
      endcase
    end
    else if (rd_en)
    begin
      rd_refused <= (rd_sel == R_SP || rd_sel == R_BANK);
      case (rd_sel)
        R_A: rd_data <= {4'h0, acc_a};
        R_B: rd_data <= {4'h0, acc_b};
        R_H: rd_data <= {4'h0, idx_h};
        R_L: rd_data <= {4'h0, idx_l};
        R_X: rd_data <= {4'h0, idx_x};
        R_Y: rd_data <= {4'h0, idx_y};
        default: rd_data <= 8'h00;
      endcase
    end
  end

  // bank for a memory request
  always_comb
  begin
    case (mem_mode)
      M_HL: next_bank = bank_of(primary_bank_select);
      M_XY: next_bank = bank_enable_flag ?
        bank_of(secondary_bank_select) : bank_of(primary_bank_select);
      M_DIR:
      begin
        // common area forced to bank 0
        if (bank_common_flag && mem_dir <= COMMON_LAST)
          next_bank = BANK0;
        else if (bank_enable_flag)
          next_bank = bank_of(secondary_bank_select);
        else
          next_bank = bank_of(primary_bank_select);
      end
      default: next_bank = BANK7;
    endcase
  end

  // data memory port
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dmem_addr <= 11'h000;
      dmem_en <= 1'b0;
      dmem_we <= 1'b0;
      dmem_byte <= 1'b0;
      dmem_wdata <= 8'h00;
    end
    else if (save_st != SV_IDLE)
    begin
      dmem_addr <= stack_addr(stack_pointer);
      dmem_en <= 1'b1;
      dmem_we <= 1'b1;
      dmem_byte <= 1'b1;
      case (save_st)
        SV_BA: dmem_wdata <= {acc_b, acc_a};
        SV_HL: dmem_wdata <= {idx_h, idx_l};
        default: dmem_wdata <= {7'h00, carry};
      endcase
    end
    else if (do_push || do_pop)
    begin
      dmem_addr <= stack_addr(do_push ? stack_pointer : sp_up);
      dmem_en <= 1'b1;
      dmem_we <= do_push;
      dmem_byte <= 1'b1;
      dmem_wdata <= push_data;
    end
    else if (mem_go)
    begin
      dmem_en <= 1'b1;
      dmem_we <= mem_we;
      dmem_wdata <= mem_wdata;
      // stack mode pairs in bank 7
      if (mem_mode == M_SP)
      begin
        dmem_addr <= stack_addr(stack_pointer);
        dmem_byte <= 1'b1;
      end
      else
      begin
        dmem_byte <= mem_byte;
        case (mem_mode)
          M_HL: dmem_addr <= {next_bank, idx_h, idx_l};
          M_XY: dmem_addr <= {next_bank, idx_x, idx_y};
          default: dmem_addr <= {next_bank, mem_dir};
        endcase
      end
    end
    else
    begin
      dmem_en <= 1'b0;
      dmem_we <= 1'b0;
    end
  end

  // region flags of the last address
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dmem_sfr <= 1'b0;
      dmem_stack <= 1'b0;
    end
    else
    begin
      dmem_sfr <= (next_bank == BANK0) && (mem_dir <= SFR_TOP)
        && mem_go && mem_mode == M_DIR;
      dmem_stack <= (save_st != SV_IDLE) || do_push || do_pop
        || (mem_go && mem_mode == M_SP);
    end
  end

  // interrupt save writes two pairs and the carry
  sequence s_save_writes;
    dmem_we && dmem_byte ##1 dmem_we && dmem_byte ##1 dmem_we && dmem_byte;
  endsequence

  a_reset_start: assert property (@(posedge clk)
    $rose(rst_n) |-> program_counter == PC_RESET
      && stack_pointer == SP_RESET)
    else $error("reset values of pc or sp wrong");
  a_sp_ends_one: assert property (@(posedge clk) disable iff (!rst_n)
    stack_pointer[7] && stack_pointer[0])
    else $error("stack pointer end bit not one");
  a_push_down: assert property (@(posedge clk) disable iff (!rst_n)
    do_push |=> stack_pointer[6:1] == $past(stack_pointer[6:1]) - SP_STEP)
    else $error("push did not count down");
  a_nibble_keep: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && !reg_byte && idle && !intr_take && !sp_push && !sp_pop
      |=> $stable(stack_pointer))
    else $error("nibble write changed stack pointer");
  a_common_bank: assert property (@(posedge clk) disable iff (!rst_n)
    mem_go && mem_mode == M_DIR && bank_common_flag
      && mem_dir <= COMMON_LAST |=> dmem_addr[10:8] == BANK0)
    else $error("common area not bank 0");
  a_sp_mode_bank: assert property (@(posedge clk) disable iff (!rst_n)
    mem_go && mem_mode == M_SP
      |=> dmem_addr[10:8] == BANK7 && !dmem_addr[0] && dmem_byte)
    else $error("stack mode address wrong");
  a_intr_save: assert property (@(posedge clk) disable iff (!rst_n)
    do_intr |=> ##1 s_save_writes ##0 save_st == SV_IDLE)
    else $error("interrupt save sequence wrong");
  a_zp_entry: assert property (@(posedge clk) disable iff (!rst_n)
    zp_call && !do_intr |=> program_counter >= ZPC_BASE
      && program_counter <= ZPC_LAST)
    else $error("zero-page call outside entry area");
  a_intr_entry: assert property (@(posedge clk) disable iff (!rst_n)
    do_intr |=> program_counter >= INT_BASE
      && program_counter <= INT_LAST)
    else $error("interrupt entry outside area");
endmodule

// *** inc/cra_pkg.sv ***
package cra_pkg;
  // clock rates, hz
  localparam int CLK_HZ = 40000000;
  localparam int XTAL_HZ = 32768;
  localparam int RC_HZ = 400000;
  // divider top counts, fast clocks per core clock less one, rounded down
  localparam logic [10:0] XTAL_TOP = 11'(CLK_HZ / XTAL_HZ - 1);
  localparam logic [10:0] RC_TOP = 11'(CLK_HZ / RC_HZ - 1);
  // machine cycles per instruction
  localparam logic [2:0] MC_MIN = 3'h1;
  localparam logic [2:0] MC_MAX = 3'h5;
  // program memory map
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [11:0] ZPC_BASE = 12'h010;
  localparam logic [11:0] ZPC_LAST = 12'h01f;
  localparam logic [11:0] INT_BASE = 12'h020;
  localparam logic [11:0] INT_LAST = 12'h03d;
  localparam logic [11:0] TEST_BASE = 12'hfe0;
  localparam logic [3:0] INT_IDX_MAX = 4'he;
  // data memory map
  localparam logic [2:0] BANK0 = 3'h0;
  localparam logic [2:0] BANK7 = 3'h7;
  localparam logic [7:0] COMMON_LAST = 8'h7f;
  localparam logic [7:0] SFR_TOP = 8'h7f;
  localparam logic [7:0] STACK_LOW = 8'h80;
  localparam logic [7:0] SP_RESET = 8'hff;
  localparam logic [5:0] SP_STEP = 6'h01;
  // bank register byte layout
  localparam int BK_PRIMARY_BANK_SELECT_LSB = 0;
  localparam int BK_SECONDARY_BANK_SELECT_LSB = 3;
  localparam int BK_BEF_BIT = 6;
  localparam int BK_BCF_BIT = 7;
  // state within a machine cycle
  typedef enum logic [1:0] {
    ST_S1 = 2'b00, ST_S2 = 2'b01, ST_S3 = 2'b10
  } cra_state_t;
  // interrupt save sequence
  typedef enum logic [1:0] {
    SV_IDLE = 2'b00, SV_BA = 2'b01, SV_HL = 2'b10, SV_C = 2'b11
  } cra_save_t;
  // register select
  typedef enum logic [2:0] {
    R_A = 3'b000, R_B = 3'b001, R_H = 3'b010, R_L = 3'b011,
    R_X = 3'b100, R_Y = 3'b101, R_SP = 3'b110, R_BANK = 3'b111
  } cra_reg_t;
  // data memory addressing mode
  typedef enum logic [1:0] {
    M_HL = 2'b00, M_XY = 2'b01, M_DIR = 2'b10, M_SP = 2'b11
  } cra_mode_t;
endpackage

// *** src/cra_timing.sv ***
`timescale 1ns/1ps
module cra_timing
  import cra_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // oscillator choice, 1 selects rc
  input wire logic osc_rc,
  // length of next instruction in machine cycles
  input wire logic [2:0] cyc_len,
  // timing outputs
  output logic tick,
  output cra_state_t state,
  output logic [2:0] mcycle,
  output logic instr_start
);
  // fast clock divider count
  logic [10:0] div_cnt;
  // latched instruction length
  logic [2:0] len;

  // keep length within one to five
  function automatic logic [2:0] clamp_len(input logic [2:0] n);
    if (n < MC_MIN)
      return MC_MIN;
    else if (n > MC_MAX)
      return MC_MAX;
    return n;
  endfunction

  // core clock period from selected oscillator
  // oscillator rate select
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_cnt <= 11'h000;
      tick <= 1'b0;
    end
    else if (div_cnt >= (osc_rc ? RC_TOP : XTAL_TOP))
    begin
      div_cnt <= 11'h000;
      tick <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 11'h001;
      tick <= 1'b0;
    end
  end

  // one state per core clock period
  // three states per cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state <= ST_S1;
    else if (tick)
    begin
      case (state)
        ST_S1: state <= ST_S2;
        ST_S2: state <= ST_S3;
        default: state <= ST_S1;
      endcase
    end
  end

  // machine cycle count within instruction
  // one to five cycles
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mcycle <= MC_MIN;
      len <= MC_MIN;
      instr_start <= 1'b0;
    end
    else
    begin
      instr_start <= 1'b0;
      if (tick && state == ST_S3)
      begin
        if (mcycle >= len)
        begin
          mcycle <= MC_MIN;
          len <= clamp_len(cyc_len);
          instr_start <= 1'b1;
        end
        else
          mcycle <= mcycle + 3'h1;
      end
    end
  end

  a_state_order: assert property (@(posedge clk) disable iff (!rst_n)
    tick && state == ST_S1 |=> state == ST_S2)
    else $error("state did not step from s1 to s2");
  a_mcycle_range: assert property (@(posedge clk) disable iff (!rst_n)
    mcycle >= MC_MIN && mcycle <= MC_MAX)
    else $error("machine cycle out of range");
endmodule

// *** verification/tb_cra_regs_address_map.sv ***
`timescale 1ns/1ps
module tb_cpu_regs_address_map;
  import cra_pkg::*;
  // clock, reset and tallies
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  int fails = 0;
  int checks_done = 0;
  // inputs, all given a value at time zero
  logic osc_rc = 1'b1;
  logic [2:0] cyc_len = 3'h1;
  logic pc_inc = 1'b0, pc_load = 1'b0, zp_call = 1'b0, intr_take = 1'b0;
  logic [11:0] pc_value = 12'h000;
  logic [2:0] zp_index = 3'h0;
  logic [3:0] intr_index = 4'h0;
  logic reg_wr = 1'b0, reg_byte = 1'b0, rd_en = 1'b0, rd_byte = 1'b0;
  cra_reg_t reg_sel = R_A, rd_sel = R_A;
  logic [7:0] reg_wdata = 8'h00, push_data = 8'h00;
  logic carry_we = 1'b0, carry_in = 1'b0, sp_push = 1'b0, sp_pop = 1'b0;
  logic mem_req = 1'b0, mem_we = 1'b0, mem_byte = 1'b0;
  cra_mode_t mem_mode = M_HL;
  logic [7:0] mem_dir = 8'h00, mem_wdata = 8'h00;
  // outputs
  logic tick, instr_start, fetch_in_test, intr_busy, rd_refused, carry;
  cra_state_t state;
  logic [2:0] mcycle;
  logic [11:0] program_counter;
  logic [7:0] rd_data, stack_pointer, dmem_wdata;
  logic [10:0] dmem_addr;
  logic dmem_en, dmem_we, dmem_byte, dmem_sfr, dmem_stack;
  // data port address, strobes and write data in one word, for short compares
  logic [21:0] dm_all;
  assign dm_all = {dmem_addr, dmem_en, dmem_we, dmem_byte, dmem_wdata};
  // scratch
  logic [7:0] q;
  logic rf;
  int n;
  cra_state_t s0;

  // compare, count and report at once
  `define chk(nm, ex, got) \
  begin \
    checks_done++; \
    if ((got) !== (ex)) \
    begin \
      fails++; \
      $display("[ERR] %s expected %h seen %h", nm, ex, got); \
    end \
  end

  cra_core_regs cra_core_regs_i (.clk(clk), .rst_n(rst_n), .osc_rc(osc_rc),
    .cyc_len(cyc_len), .tick(tick), .state(state), .mcycle(mcycle),
    .instr_start(instr_start), .pc_inc(pc_inc), .pc_load(pc_load),
    .pc_value(pc_value), .zp_call(zp_call), .zp_index(zp_index),
    .intr_take(intr_take), .intr_index(intr_index),
    .program_counter(program_counter), .fetch_in_test(fetch_in_test),
    .intr_busy(intr_busy), .reg_wr(reg_wr), .reg_byte(reg_byte),
    .reg_sel(reg_sel), .reg_wdata(reg_wdata), .rd_en(rd_en),
    .rd_byte(rd_byte), .rd_sel(rd_sel), .rd_data(rd_data),
    .rd_refused(rd_refused), .carry_we(carry_we), .carry_in(carry_in),
    .carry(carry), .sp_push(sp_push), .sp_pop(sp_pop),
    .push_data(push_data), .stack_pointer(stack_pointer),
    .mem_req(mem_req), .mem_mode(mem_mode), .mem_dir(mem_dir),
    .mem_we(mem_we), .mem_byte(mem_byte), .mem_wdata(mem_wdata),
    .dmem_addr(dmem_addr), .dmem_en(dmem_en), .dmem_we(dmem_we),
    .dmem_byte(dmem_byte), .dmem_wdata(dmem_wdata), .dmem_sfr(dmem_sfr),
    .dmem_stack(dmem_stack));

  // 25 ns clock
  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // move to just after the next rising edge
  task automatic step();
    @(posedge clk);
    #2;
  endtask

  // register write, held for one taking edge
  task automatic wr(input cra_reg_t sel, input logic byt, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_byte = byt;
    reg_sel = sel;
    reg_wdata = d;
    step();
    reg_wr = 1'b0;
    step();
  endtask

  // register read, answer caught after the taking edge
  task automatic rd(input cra_reg_t sel, input logic byt);
    rd_en = 1'b1;
    rd_byte = byt;
    rd_sel = sel;
    step();
    q = rd_data;
    rf = rd_refused;
    rd_en = 0;
    step();
  endtask

  // expected data address from bank byte, mode and offset
  function automatic logic [10:0] exp_addr(input cra_mode_t m,
    input logic [7:0] off, input logic [7:0] bk);
    logic [2:0] sel;
    logic [2:0] b;
    sel = (m == M_HL || !bk[6]) ? bk[2:0] : bk[5:3];
    b = sel[0] ? 3'h7 : 3'h0;
    if (m == M_DIR && bk[7] && off <= 8'h7f)
      b = 3'h0;
    return {b, off};
  endfunction

  // one data memory request and its issued address
  task automatic mreq(input cra_mode_t m, input logic [7:0] off,
    input logic [7:0] bk);
    logic [10:0] e;
    e = exp_addr(m, off, bk);
    mem_req = 1'b1;
    mem_mode = m;
    mem_dir = off;
    mem_we = off[0];
    mem_wdata = off;
    step();
    `chk("dmem_addr", e, dmem_addr)
    `chk("dmem_we", {1'b1, off[0]}, {dmem_en, dmem_we})
    `chk("dmem_sfr", m == M_DIR && e[10:8] == 3'h0 && !off[7], dmem_sfr)
    `chk("dmem_stack", 1'b0, dmem_stack)
    mem_req = 1'b0;
    step();
  endtask

  // cycles between two ticks, with the state step across them
  task automatic gap(output int g);
    int w;
    cra_state_t nx;
    w = 0;
    while (tick !== 1'b1 && w < 3000)
    begin
      step();
      w++;
    end
    s0 = state;
    step();
    g = 1;
    while (tick !== 1'b1 && w < 3000)
    begin
      step();
      g++;
      w++;
    end
    nx = (s0 == ST_S3) ? ST_S1 : cra_state_t'(s0 + 2'h1);
    `chk("state", nx, state)
  endtask

  // ticks between two instruction starts
  task automatic span(output int t);
    int w;
    w = 0;
    t = 0;
    while (instr_start !== 1'b1 && w < 3000)
    begin
      step();
      w++;
    end
    step();
    while (instr_start !== 1'b1 && w < 3000)
    begin
      t += int'(tick === 1'b1);
      step();
      w++;
    end
  endtask

  // verdict, the only way out
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // hang guard, well past the expected run length
  initial
  begin
    #(25 * 60000);
    fails++;
    conclude();
  end

  // main sequence
  initial
  begin
    int lens[4] = '{1, 5, 0, 7};
    int tks[4] = '{3, 15, 3, 15};
    repeat (10) @(posedge clk);
    #2;
    rst_n = 1'b1;
    `chk("pc", PC_RESET, program_counter)
    `chk("sp", 8'hff, stack_pointer)
    `chk("mcycle", 3'h1, mcycle)
    // stack pointer access kinds and fixed ends
    wr(R_SP, 1'b1, 8'h00);
    `chk("sp", 8'h81, stack_pointer)
    rd(R_SP, 1'b1);
    `chk("sp read", 8'h81, q)
    wr(R_SP, 1'b0, 8'h3c);
    `chk("sp nibble wr", 8'h81, stack_pointer)
    rd(R_SP, 1'b0);
    `chk("sp nibble rd", 9'h100, {rf, q})
    wr(R_SP, 1'b1, 8'hff);
    // push, pop, wrap at the top and the bottom of the stack
    sp_push = 1'b1;
    push_data = 8'h5a;
    step();
    `chk("push", {11'h7fe, 3'h7, 8'h5a}, dm_all)
    `chk("stack flag", 1'b1, dmem_stack)
    `chk("sp", 8'hfd, stack_pointer)
    sp_push = 1'b0;
    sp_pop = 1'b1;
    step();
    `chk("pop", {11'h7fe, 2'h2}, {dmem_addr, dmem_en, dmem_we})
    `chk("sp", 8'hff, stack_pointer)
    step();
    `chk("sp wrap", 8'h81, stack_pointer)
    sp_pop = 1'b0;
    sp_push = 1'b1;
    step();
    `chk("stack low", 11'h780, dmem_addr)
    `chk("sp", 8'hff, stack_pointer)
    sp_push = 1'b0;
    // interrupt save of pairs and carry
    wr(R_A, 1'b1, 8'hb6);
    wr(R_H, 1'b1, 8'h4d);
    carry_we = 1'b1;
    carry_in = 1'b1;
    step();
    carry_we = 1'b0;
    `chk("carry", 1'b1, carry)
    intr_index = 4'h2;
    intr_take = 1'b1;
    step();
    intr_take = 1'b0;
    `chk("pc", 12'h024, program_counter)
    `chk("intr_busy", 1'b1, intr_busy)
    step();
    `chk("save ba", {11'h7fe, 3'h7, 8'hb6}, dm_all)
    step();
    `chk("save hl", {11'h7fc, 8'h4d}, {dmem_addr, dmem_wdata})
    step();
    `chk("save c", {11'h7fa, 8'h01}, {dmem_addr, dmem_wdata})
    `chk("sp", 8'hf9, stack_pointer)
    step();
    intr_index = 4'hf;
    intr_take = 1'b1;
    step();
    intr_take = 1'b0;
    `chk("pc", 12'h03c, program_counter)
    repeat (4) step();
    // program counter wrap and zero-page entries
    pc_load = 1'b1;
    pc_value = 12'hfff;
    step();
    `chk("test area", 1'b1, fetch_in_test)
    pc_load = 1'b0;
    pc_inc = 1'b1;
    step();
    `chk("pc wrap", 12'h000, program_counter)
    `chk("test area", 1'b0, fetch_in_test)
    zp_call = 1'b1;
    zp_index = 3'h7;
    step();
    zp_call = 1'b0;
    pc_inc = 1'b0;
    `chk("pc zp", 12'h01e, program_counter)
    // bank selection over flags, selects and modes
    for (int i = 0; i < 16; i++)
    begin
      q = {i[3:2], 3'(i * 5), 3'(i * 3)};
      wr(R_BANK, 1'b1, q);
      for (int k = 0; k < 2; k++)
      begin
        wr(R_H, 1'b1, k ? 8'hc3 : 8'h3c);
        wr(R_X, 1'b1, k ? 8'hc3 : 8'h3c);
        mreq(M_HL, k ? 8'hc3 : 8'h3c, q);
        mreq(M_XY, k ? 8'hc3 : 8'h3c, q);
        mreq(M_DIR, k ? 8'hc3 : 8'h3c, q);
      end
    end
    wr(R_BANK, 1'b1, 8'h80);
    mreq(M_DIR, 8'h7f, 8'h80);
    // pair and nibble reads of the last index values
    rd(R_X, 1'b1);
    `chk("xy pair", 8'hc3, q)
    rd(R_L, 1'b0);
    `chk("l nibble", 9'h003, {rf, q})
    // stack mode forces bank 7 pairs
    wr(R_SP, 1'b1, 8'h95);
    mem_req = 1'b1;
    mem_mode = M_SP;
    mem_byte = 1'b0;
    step();
    `chk("sp mode", {11'h794, 2'h3}, {dmem_addr, dmem_byte, dmem_stack})
    mem_req = 1'b0;
    // machine cycle lengths, clamped at both ends
    for (int i = 0; i < 4; i++)
    begin
      cyc_len = 3'(lens[i]);
      span(n);
      span(n);
      `chk("ticks", tks[i], n)
    end
    // core clock rate for both sources
    gap(n);
    `chk("rc gap", int'(RC_TOP) + 1, n)
    osc_rc = 1'b0;
    gap(n);
    gap(n);
    `chk("xtal gap", int'(XTAL_TOP) + 1, n)
    conclude();
  end
endmodule
